// File: inc/pqar_pkg.sv
package pqar_pkg;
  localparam int NQ = 8;
  localparam int NP = 4;
  localparam int DW = 128;
  localparam int PW = 2;
  localparam int LW = 3;
  localparam int QD = 4;
  localparam int QAW = 2;
  localparam int FLOWS = 64;
  localparam int FIW = 6;
  localparam int TIW = 4;
  // Header fields inside the first 128-bit word of a packet.
  localparam int FLOW_LSB = 0;
  localparam int FLUSH_BIT = 8;
  localparam int TGT_LSB = 64;
  localparam logic [TIW-1:0] TGT_TRAFFIC_MGR = 4'h0;
  // Register byte addresses.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TX_DMA_PRIO = 8'h04;
  localparam logic [7:0] A_TX_QF_PRIO = 8'h08;
  localparam logic [7:0] A_TX_DEST_SEL = 8'h0c;
  localparam logic [7:0] A_RX_PRIO = 8'h10;
  localparam logic [7:0] A_FLOW_IDX = 8'h14;
  localparam logic [7:0] A_FLOW_DATA = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1c;
  localparam logic [31:0] CTRL_RST = 32'h00000001;
  localparam int CTRL_RAISE_BIT = 0;
  localparam int ST_BLK = 0;
  localparam int ST_NE = 8;
  localparam int ST_RAI = 16;
  localparam int FE_W = 5;

  typedef struct packed {
    logic eop;
    logic [DW-1:0] data;
  } pqar_word_type;

  typedef struct packed {
    logic int_en;
    logic endian;
    logic [2:0] chan;
  } pqar_flow_type;
endpackage

// File: rtl/pqar_top.sv
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
module pqar_top (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [7:0] i_dma_avail,
  output logic [7:0] o_dma_pop,
  input wire pqar_pkg::pqar_word_type i_dma_word,
  output logic [3:0] o_sw_valid,
  output pqar_pkg::pqar_word_type [3:0] o_sw_word,
  output logic [3:0][3:0] o_sw_target,
  input wire logic [3:0] i_sw_ready,
  input wire logic [3:0] i_swr_valid,
  input wire pqar_pkg::pqar_word_type [3:0] i_swr_word,
  output logic [3:0] o_swr_ready,
  output logic o_rx_valid,
  output pqar_pkg::pqar_word_type o_rx_word,
  output logic [2:0] o_rx_chan,
  output logic o_rx_endian,
  output logic o_rx_int_en,
  input wire logic i_rx_ready
);

  // Priority pick: lowest level wins, ties go round robin from the pointer.
  function automatic logic [7:0] arb(input logic [7:0] req, input logic [23:0] lv, input logic [2:0] ptr);
    logic [7:0] g;
    logic [2:0] best;
    logic found;
    int i;
    g = '0;
    best = 3'h7;
    found = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (req[k] && lv[k*3+:3] < best) begin
        best = lv[k*3+:3];
      end
    end
    for (int k = 0; k < 8; k++) begin
      i = (int'(ptr) + k) % 8;
      if (!found && req[i] && lv[i*3+:3] == best) begin
        g[i] = 1'b1;
        found = 1'b1;
      end
    end
    return g;
  endfunction

  function automatic logic [2:0] idx(input logic [7:0] oh);
    logic [2:0] r;
    r = '0;
    for (int k = 0; k < 8; k++) begin
      if (oh[k]) begin
        r = 3'(k);
      end
    end
    return r;
  endfunction

  logic [31:0] ctrl;
  logic [15:0] tx_dma_prio;
  logic [15:0] tx_qf_prio;
  logic [15:0] tx_dest_sel;
  logic [7:0] rx_prio;
  logic [pqar_pkg::FIW-1:0] flow_idx;
  pqar_pkg::pqar_flow_type flow_tab [pqar_pkg::FLOWS];
  logic [7:0] blk;
  logic [7:0] raised;
  logic [7:0] nonempty;
  logic apb_setup;
  logic apb_wr;

  // Registers are written in the access phase; pready is always high.
  assign apb_setup = i_psel & ~i_penable;
  assign apb_wr = i_psel & i_penable & i_pwrite;
  assign o_pready = 1'b1;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl <= pqar_pkg::CTRL_RST;
      tx_dma_prio <= '0;
      tx_qf_prio <= '0;
      tx_dest_sel <= '0;
      rx_prio <= '0;
      flow_idx <= '0;
    end else if (apb_wr) begin
      if (i_paddr == pqar_pkg::A_CTRL) begin
        ctrl <= i_pwdata;
      end else if (i_paddr == pqar_pkg::A_TX_DMA_PRIO) begin
        tx_dma_prio <= i_pwdata[15:0];
      end else if (i_paddr == pqar_pkg::A_TX_QF_PRIO) begin
        tx_qf_prio <= i_pwdata[15:0];
      end else if (i_paddr == pqar_pkg::A_TX_DEST_SEL) begin
        tx_dest_sel <= i_pwdata[15:0];
      end else if (i_paddr == pqar_pkg::A_RX_PRIO) begin
        rx_prio <= i_pwdata[7:0];
      end else if (i_paddr == pqar_pkg::A_FLOW_IDX) begin
        flow_idx <= i_pwdata[pqar_pkg::FIW-1:0];
      end
    end
  end

  // The flow table has no reset; software must load it before traffic.
  always_ff @(posedge i_clk) begin
    if (apb_wr && i_paddr == pqar_pkg::A_FLOW_DATA) begin
      flow_tab[flow_idx] <= i_pwdata[pqar_pkg::FE_W-1:0];
    end
  end

  // Read data is registered in the setup cycle so it is stable in access.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end else if (apb_setup) begin
      o_pslverr <= 1'b0;
      if (i_paddr == pqar_pkg::A_CTRL) begin
        o_prdata <= ctrl;
      end else if (i_paddr == pqar_pkg::A_TX_DMA_PRIO) begin
        o_prdata <= {16'h0000, tx_dma_prio};
      end else if (i_paddr == pqar_pkg::A_TX_QF_PRIO) begin
        o_prdata <= {16'h0000, tx_qf_prio};
      end else if (i_paddr == pqar_pkg::A_TX_DEST_SEL) begin
        o_prdata <= {16'h0000, tx_dest_sel};
      end else if (i_paddr == pqar_pkg::A_RX_PRIO) begin
        o_prdata <= {24'h000000, rx_prio};
      end else if (i_paddr == pqar_pkg::A_FLOW_IDX) begin
        o_prdata <= {26'h0000000, flow_idx};
      end else if (i_paddr == pqar_pkg::A_FLOW_DATA) begin
        o_prdata <= {27'h0000000, flow_tab[flow_idx]};
      end else if (i_paddr == pqar_pkg::A_STATUS) begin
        o_prdata <= '0;
        o_prdata[pqar_pkg::ST_BLK+:8] <= blk;
        o_prdata[pqar_pkg::ST_NE+:8] <= nonempty;
        o_prdata[pqar_pkg::ST_RAI+:8] <= raised;
      end else begin
        o_prdata <= '0;
        o_pslverr <= 1'b1;
      end
    end
  end

  // Ingress staging FIFOs, one per transmit queue.
  pqar_pkg::pqar_word_type qf_mem [pqar_pkg::NQ][pqar_pkg::QD];
  logic [pqar_pkg::QAW-1:0] wp [pqar_pkg::NQ];
  logic [pqar_pkg::QAW-1:0] rp [pqar_pkg::NQ];
  logic [pqar_pkg::QAW:0] cnt [pqar_pkg::NQ];
  logic [7:0] in_sop;
  logic [7:0] in_flush;
  logic [7:0] room;
  logic [7:0] wr;
  logic [7:0] pop;
  logic [7:0] blk_clr;
  logic [23:0] lv_in;
  logic [2:0] in_ptr;

  // DMA-read stage: raised queues sit four levels below the normal ones, so they win.
  always_comb begin
    for (int q = 0; q < 8; q++) begin
      lv_in[q*3+:3] = {~raised[q], tx_dma_prio[q*2+:2]};
    end
    wr = arb(i_dma_avail & room & ~blk, lv_in, in_ptr);
  end
  assign o_dma_pop = wr;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      in_ptr <= '0;
    end else if (|wr) begin
      in_ptr <= idx(wr) + 3'h1;
    end
  end

  for (genvar q = 0; q < pqar_pkg::NQ; q++) begin : g_q
    assign room[q] = cnt[q] < (pqar_pkg::QAW+1)'(pqar_pkg::QD);
    assign nonempty[q] = cnt[q] != '0;

    always_ff @(posedge i_clk) begin
      if (wr[q]) begin
        qf_mem[q][wp[q]] <= i_dma_word;
      end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        wp[q] <= '0;
        rp[q] <= '0;
        cnt[q] <= '0;
      end else begin
        if (wr[q]) begin
          wp[q] <= wp[q] + 1'b1;
        end
        if (pop[q]) begin
          rp[q] <= rp[q] + 1'b1;
        end
        cnt[q] <= cnt[q] + {{pqar_pkg::QAW{1'b0}}, wr[q]} - {{pqar_pkg::QAW{1'b0}}, pop[q]};
      end
    end

    // A flush packet closes its FIFO once its last word is in; a new flush wins over a clear.
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        in_sop[q] <= 1'b1;
        in_flush[q] <= 1'b0;
        blk[q] <= 1'b0;
      end else begin
        if (wr[q]) begin
          in_sop[q] <= i_dma_word.eop;
          in_flush[q] <= i_dma_word.eop ? 1'b0 : (in_sop[q] ? i_dma_word.data[pqar_pkg::FLUSH_BIT] : in_flush[q]);
        end
        if (wr[q] && i_dma_word.eop && (in_sop[q] ? i_dma_word.data[pqar_pkg::FLUSH_BIT] : in_flush[q])) begin
          blk[q] <= 1'b1;
        end else if (blk_clr[q]) begin
          blk[q] <= 1'b0;
        end
      end
    end
  end

  // Final stage: one arbiter per switch port over the FIFOs mapped to it.
  logic [7:0] port_pop [pqar_pkg::NP];
  logic [7:0] port_act [pqar_pkg::NP];
  logic sw_v [pqar_pkg::NP];
  pqar_pkg::pqar_word_type sw_w [pqar_pkg::NP];
  logic [3:0] sw_t [pqar_pkg::NP];

  always_comb begin
    pop = '0;
    raised = '0;
    for (int p = 0; p < 4; p++) begin
      pop = pop | port_pop[p];
      raised = raised | (ctrl[pqar_pkg::CTRL_RAISE_BIT] ? port_act[p] : 8'h00);
      o_sw_valid[p] = sw_v[p];
      o_sw_word[p] = sw_w[p];
      o_sw_target[p] = sw_t[p];
    end
  end

  for (genvar p = 0; p < pqar_pkg::NP; p++) begin : g_p
    logic lock;
    logic sop;
    logic [7:0] own;
    logic [7:0] req;
    logic [7:0] sel;
    logic [23:0] lv;
    logic [2:0] ptr;
    logic go;
    pqar_pkg::pqar_word_type w;

    always_comb begin
      for (int q = 0; q < 8; q++) begin
        req[q] = nonempty[q] && tx_dest_sel[q*2+:2] == 2'(p);
        lv[q*3+:3] = {1'b0, tx_qf_prio[q*2+:2]};
      end
      sel = lock ? own : arb(req, lv, ptr);
      go = (~sw_v[p] | i_sw_ready[p]) & |(sel & req);
      port_pop[p] = go ? sel : 8'h00;
      port_act[p] = lock ? own : 8'h00;
      w = qf_mem[idx(sel)][rp[idx(sel)]];
    end

    // The word register holds data until the switch takes it.
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        sw_v[p] <= 1'b0;
        sw_w[p] <= '0;
        sw_t[p] <= '0;
        lock <= 1'b0;
        sop <= 1'b1;
        own <= '0;
        ptr <= '0;
      end else if (go) begin
        sw_v[p] <= 1'b1;
        sw_w[p] <= w;
        if (sop) begin
          sw_t[p] <= w.data[pqar_pkg::TGT_LSB+:pqar_pkg::TIW];
        end
        lock <= ~w.eop;
        sop <= w.eop;
        own <= sel;
        if (!lock) begin
          ptr <= idx(sel) + 3'h1;
        end
      end else if (i_sw_ready[p]) begin
        sw_v[p] <= 1'b0;
      end
    end
  end

  // Egress: each port's packet returns on its own port and picks its channel by flow.
  logic [3:0] rsop;
  pqar_pkg::pqar_flow_type rent [pqar_pkg::NP];
  logic [3:0] rflush;
  pqar_pkg::pqar_flow_type ent [pqar_pkg::NP];
  logic [3:0] efl;
  logic [7:0] elig;
  logic [7:0] eg;
  logic [23:0] elv;
  logic [2:0] eptr;
  logic [7:0] own_v;
  logic [1:0] own_p [pqar_pkg::NQ];
  logic [1:0] gp;
  logic [1:0] out_port;
  logic out_flush;

  always_comb begin
    elig = '0;
    elv = '0;
    for (int p = 0; p < 4; p++) begin
      ent[p] = rsop[p] ? flow_tab[i_swr_word[p].data[pqar_pkg::FLOW_LSB+:pqar_pkg::FIW]] : rent[p];
      efl[p] = rsop[p] ? i_swr_word[p].data[pqar_pkg::FLUSH_BIT] : rflush[p];
      elig[p] = i_swr_valid[p] && (!own_v[ent[p].chan] || own_p[ent[p].chan] == 2'(p));
      elv[p*3+:3] = {1'b0, rx_prio[p*2+:2]};
    end
    eg = (~o_rx_valid | i_rx_ready) ? arb(elig, elv, eptr) : 8'h00;
    gp = 2'(idx(eg));
    o_swr_ready = eg[3:0];
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rsop <= 4'hf;
      rflush <= '0;
      for (int p = 0; p < 4; p++) begin
        rent[p] <= '0;
      end
    end else begin
      for (int p = 0; p < 4; p++) begin
        if (eg[p]) begin
          rsop[p] <= i_swr_word[p].eop;
          rent[p] <= ent[p];
          rflush[p] <= efl[p];
        end
      end
    end
  end

  // A channel stays owned by one port from first to last word.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      own_v <= '0;
      eptr <= '0;
      for (int c = 0; c < 8; c++) begin
        own_p[c] <= '0;
      end
    end else if (|eg) begin
      own_v[ent[gp].chan] <= ~i_swr_word[gp].eop;
      own_p[ent[gp].chan] <= gp;
      if (!own_v[ent[gp].chan]) begin
        eptr <= {1'b0, gp} + 3'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rx_valid <= 1'b0;
      o_rx_word <= '0;
      o_rx_chan <= '0;
      o_rx_endian <= 1'b0;
      o_rx_int_en <= 1'b0;
      out_port <= '0;
      out_flush <= 1'b0;
    end else if (|eg) begin
      o_rx_valid <= 1'b1;
      o_rx_word <= i_swr_word[gp];
      o_rx_chan <= ent[gp].chan;
      o_rx_endian <= ent[gp].endian;
      o_rx_int_en <= ent[gp].int_en;
      out_port <= gp;
      out_flush <= efl[gp];
    end else if (i_rx_ready) begin
      o_rx_valid <= 1'b0;
    end
  end

  // The flush end on a port reopens every blocked FIFO mapped to that port.
  always_comb begin
    for (int q = 0; q < 8; q++) begin
      blk_clr[q] = o_rx_valid && i_rx_ready && o_rx_word.eop && out_flush && tx_dest_sel[q*2+:2] == out_port;
    end
  end

endmodule // pqar_top

// File: testbench/pqar_assertions.sv
`timescale 1ns/1ps
// Port-level checks on the arbiter; it sees only ports of the top module.
module pqar_assertions (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic [7:0] i_dma_avail,
  input wire logic [7:0] o_dma_pop,
  input wire logic [3:0] o_sw_valid,
  input wire pqar_pkg::pqar_word_type [3:0] o_sw_word,
  input wire logic [3:0][3:0] o_sw_target,
  input wire logic [3:0] i_sw_ready,
  input wire logic [3:0] i_swr_valid,
  input wire logic [3:0] o_swr_ready,
  input wire logic o_rx_valid,
  input wire pqar_pkg::pqar_word_type o_rx_word,
  input wire logic [2:0] o_rx_chan,
  input wire logic i_rx_ready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Setup phase of an APB transfer, when the slave registers its answer.
  wire setup = i_psel && !i_penable;
  chk_unmapped_err: assert property (setup && i_paddr > 8'h1c |=> o_pslverr && o_prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (setup && i_paddr <= 8'h1c && i_paddr[1:0] == 2'h0 |=> !o_pslverr)
    else $error("mapped access refused");
  chk_pop_single: assert property ($onehot0(o_dma_pop))
    else $error("more than one queue popped");
  chk_pop_avail: assert property ((o_dma_pop & ~i_dma_avail) == 8'h0)
    else $error("pop without data available");
  chk_swr_single: assert property ($onehot0(o_swr_ready) && (o_swr_ready & ~i_swr_valid) == 4'h0)
    else $error("egress grant not single or not requested");
  chk_rx_answer: assert property (|o_swr_ready |=> o_rx_valid)
    else $error("egress word not handed to the dma");
  chk_rx_hold: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable({o_rx_word, o_rx_chan}))
    else $error("egress word dropped while stalled");
  for (genvar p = 0; p < 4; p++) begin : g_port
    chk_sw_hold: assert property (o_sw_valid[p] && !i_sw_ready[p] |=> o_sw_valid[p] && $stable(o_sw_word[p]))
      else $error("switch word changed while stalled");
    chk_sw_target: assert property (o_sw_valid[p] && i_sw_ready[p] && !o_sw_word[p].eop
      |=> $stable(o_sw_target[p]))
      else $error("target changed inside a packet");
  end
  cover property (o_rx_valid && i_rx_ready);
  cover property (|(o_sw_valid & i_sw_ready));
  cover property (setup ##1 o_pslverr);
endmodule // pqar_assertions

// File: testbench/pqar_dma_model.sv
`timescale 1ns/1ps
// Transmit side of the packet DMA: one pending packet per queue, a word per pop.
module pqar_dma_model (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_hold,
  input wire logic [7:0] i_pop,
  output logic [7:0] o_avail,
  output pqar_pkg::pqar_word_type o_word
);
  int rem [8] = '{default: 0};
  logic [3:0] tgt [8];
  logic [5:0] flow [8];
  logic flush [8];
  logic [7:0] junk = 8'h0;
  pqar_pkg::pqar_word_type w;
  localparam int TX_FIFO_BYTES = 640;

  // Caller must wait until the queue is empty, since only one packet is held.
  // Updates are nonblocking and land after this edge's sampling, so the design never sees a change inside the edge that samples it.
  task automatic send(input int q, input logic [5:0] f, input logic fl, input logic [3:0] t, input int len);
    flow[q] <= f;
    flush[q] <= fl;
    tgt[q] <= t;
    rem[q] <= (len * 16 > TX_FIFO_BYTES) ? TX_FIFO_BYTES / 16 : len;
  endtask

  // A held queue hides its data, which models a slow prefetch behind higher priority queues.
  always_comb begin
    for (int q = 0; q < 8; q++) begin
      o_avail[q] = rem[q] != 0 && !i_hold[q];
    end
  end

  // Idle data churns so stale words are never seen.
  always_comb begin
    w = '0;
    for (int q = 0; q < 8; q++) begin
      if (i_pop[q]) begin
        w.eop = rem[q] == 1;
        w.data[31:0] = {8'(rem[q]), 5'h0, 3'(q), 7'h0, flush[q], 2'h0, flow[q]};
        w.data[67:64] = tgt[q];
        w.data[127:96] = ~w.data[31:0];
      end
    end
    o_word = |i_pop ? w : {1'b0, {16{junk}}};
  end

  // A popped word is gone at the edge that takes it.
  always @(posedge i_clk) begin
    junk <= junk + 8'h1;
    for (int q = 0; q < 8; q++) begin
      if (i_resetn && i_pop[q]) begin
        rem[q] <= rem[q] - 1;
      end
    end
  end
endmodule // pqar_dma_model

// File: testbench/pqar_top_tb.sv
`timescale 1ns/1ps
module pqar_top_tb;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h0;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata, rd;
  logic o_pready, o_pslverr, err, o_rx_valid, o_rx_endian, o_rx_int_en;
  logic i_rx_ready = 1'b0;
  logic rx_en = 1'b1;
  logic [7:0] i_dma_avail, o_dma_pop;
  logic [7:0] hold = 8'h0;
  pqar_pkg::pqar_word_type i_dma_word, o_rx_word;
  logic [3:0] o_sw_valid, o_swr_ready;
  pqar_pkg::pqar_word_type [3:0] o_sw_word;
  logic [3:0][3:0] o_sw_target;
  logic [2:0] o_rx_chan;
  logic [15:0] seed = 16'h9028;
  logic [15:0] r;
  logic [4:0] tbl [64];
  logic [4:0] ent;
  logic [5:0] fl [8];
  logic [1:0] map [8];
  int fail_count = 0;
  int tests_run = 0;
  int sent = 0;
  int got = 0;
  int len;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  always #20 i_clk = ~i_clk;

  pqar_dma_model dma (.i_clk(i_clk), .i_resetn(i_resetn), .i_hold(hold), .i_pop(o_dma_pop),
    .o_avail(i_dma_avail), .o_word(i_dma_word));

  // The switch is a plain loop back, so each word returns on the port it left by.
  pqar_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_dma_avail(i_dma_avail), .o_dma_pop(o_dma_pop), .i_dma_word(i_dma_word),
    .o_sw_valid(o_sw_valid), .o_sw_word(o_sw_word), .o_sw_target(o_sw_target), .i_sw_ready(o_swr_ready),
    .i_swr_valid(o_sw_valid), .i_swr_word(o_sw_word), .o_swr_ready(o_swr_ready), .o_rx_valid(o_rx_valid),
    .o_rx_word(o_rx_word), .o_rx_chan(o_rx_chan), .o_rx_endian(o_rx_endian), .o_rx_int_en(o_rx_int_en),
    .i_rx_ready(i_rx_ready));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic timed_out(input int n, input int lim);
    if (n >= lim) begin
      fail_count++;
      complete_run();
    end
  endtask

  // An idle cycle closes each transfer, so no signal is assigned twice at one edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    timed_out(n, 20);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic wait_until(input int q);
    int n;
    n = 0;
    while ((q < 8 ? dma.rem[q] != 0 : got != sent) && n < 3000) begin
      @(posedge i_clk);
      n++;
    end
    timed_out(n, 3000);
  endtask

  // Stalls on both sides come from one shared generator, stepped every cycle.
  always @(posedge i_clk) begin
    seed <= lfsr(seed);
    i_rx_ready <= rx_en && (seed[0] | seed[1]);
    hold <= seed[9:2] & {8{seed[15]}};
  end

  // Egress words must carry their flow's table entry and an intact payload.
  always @(posedge i_clk) begin
    if (i_resetn && o_rx_valid && i_rx_ready) begin
      got++;
      chk({o_rx_int_en, o_rx_endian, o_rx_chan}, tbl[o_rx_word.data[5:0]]);
      chk(o_rx_word.data[127:96], ~o_rx_word.data[31:0]);
    end
    for (int p = 0; p < 4; p++) begin
      if (i_resetn && o_sw_valid[p] && o_swr_ready[p]) begin
        chk(p, map[o_sw_word[p].data[18:16]]);
        chk(o_sw_target[p], o_sw_word[p].data[67:64]);
      end
    end
  end

  initial begin
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    apb(1'b0, pqar_pkg::A_CTRL, 32'h0);
    chk(rd, pqar_pkg::CTRL_RST);
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    r = seed;
    for (int q = 0; q < 8; q++) map[q] = r[2 * q +: 2];
    apb(1'b1, pqar_pkg::A_TX_DEST_SEL, {16'h0, r});
    apb(1'b1, pqar_pkg::A_TX_DMA_PRIO, {16'h0, seed});
    apb(1'b1, pqar_pkg::A_TX_QF_PRIO, {16'h0, seed});
    apb(1'b1, pqar_pkg::A_RX_PRIO, {24'h0, seed[7:0]});
    for (int i = 0; i < 8; i++) begin
      fl[i] = seed[5:0];
      ent = seed[12:8];
      tbl[fl[i]] = ent;
      apb(1'b1, pqar_pkg::A_FLOW_IDX, {26'h0, fl[i]});
      apb(1'b1, pqar_pkg::A_FLOW_DATA, {27'h0, ent});
      apb(1'b0, pqar_pkg::A_FLOW_DATA, 32'h0);
      chk(rd, {27'h0, ent});
    end
    $display("test registers finished");
    for (int k = 0; k < 32; k++) begin
      wait_until(k % 8);
      len = 1 + int'(seed[9:8]);
      dma.send(k % 8, fl[seed[2:0]], 1'b0, seed[7:4], len);
      sent += len;
      @(posedge i_clk);
    end
    wait_until(8);
    chk(got, sent);
    $display("test traffic finished");
    apb(1'b1, pqar_pkg::A_CTRL, 32'h0);
    apb(1'b0, pqar_pkg::A_CTRL, 32'h0);
    chk(rd, 32'h0);
    rx_en <= 1'b0;
    dma.send(2, fl[0], 1'b1, 4'h0, 2);
    @(posedge i_clk);
    wait_until(2);
    dma.send(2, fl[1], 1'b0, 4'h0, 1);
    dma.send(3, fl[2], 1'b0, 4'h0, 1);
    sent += 4;
    repeat (30) @(posedge i_clk);
    chk(dma.rem[2], 1);
    chk(dma.rem[3], 0);
    apb(1'b0, pqar_pkg::A_STATUS, 32'h0);
    chk(rd[7:0], 8'h04);
    chk(rd[23:16], 8'h00);
    rx_en <= 1'b1;
    wait_until(8);
    chk(got, sent);
    apb(1'b0, pqar_pkg::A_STATUS, 32'h0);
    chk(rd[7:0], 8'h00);
    $display("test flush finished");
    complete_run();
  end
endmodule // pqar_top_tb

bind pqar_top pqar_assertions watch (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
  .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_dma_avail(i_dma_avail),
  .o_dma_pop(o_dma_pop), .o_sw_valid(o_sw_valid), .o_sw_word(o_sw_word), .o_sw_target(o_sw_target),
  .i_sw_ready(i_sw_ready), .i_swr_valid(i_swr_valid), .o_swr_ready(o_swr_ready), .o_rx_valid(o_rx_valid),
  .o_rx_word(o_rx_word), .o_rx_chan(o_rx_chan), .i_rx_ready(i_rx_ready));
